// ==== logic/io_line_peripheral_mux.sv ====
// Per-line pin multiplexer for four line controllers with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "line_mux_consts.svh"

// Contract
// - Each controller owns at most 32 lines.
// - Any line outside the memory controller may go to function A or B.
// - I/O-default lines reset as pulled-up inputs.
// - I/O-default lines reset with status bit 0.
// - Peripheral-default lines reset assigned, status 1, pulled.
// - Memory controller lines 7-13 reset to peripheral.
// - Memory controller ignores function B selection.
// - Memory controller carries upper data bus on A.
// - Upper data lines as I/O forbid wide access.
// - Output controller drives A and B as outputs.
// - Output controller exists only when build enables it.
module io_line_peripheral_mux #(
   parameter bit OUT_CTRL_PRESENT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire line_mux_pkg::axi_req_s axiReq,
   output line_mux_pkg::axi_rsp_s axiRsp,
   input wire line_mux_pkg::fn_s fnA,
   input wire line_mux_pkg::fn_s fnB,
   output line_mux_pkg::lines_t fnAIn,
   output line_mux_pkg::lines_t fnBIn,
   input wire line_mux_pkg::lines_t pinIn,
   output line_mux_pkg::pad_s pad,
   output logic wideAccessOk
);
   import line_mux_pkg::*;

   typedef struct packed {
      lines_t psel;
      lines_t bsel;
      lines_t odata;
      lines_t oen;
      lines_t pull;
      lines_t sync1;
      lines_t sync2;
      pad_s pad;
      logic wide;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_s;

   state_s state_reg;
   state_s state_next;
   logic wrFire;
   logic rdFire;

   // Lines of the output controller; none when the build leaves it out
   localparam logic [31:0] OUT_MASK = OUT_CTRL_PRESENT ? `LM_MASK_3
                                                       : 32'h00000000;

   // Lines that exist on a controller; absent controller has none
   function automatic logic [31:0] lineMask(input logic [1:0] c);
      case (c)
         2'd0: lineMask = `LM_MASK_0;
         2'd1: lineMask = `LM_MASK_1;
         2'd2: lineMask = `LM_MASK_2;
         2'd3: lineMask = OUT_CTRL_PRESENT ? `LM_MASK_3 : 32'h00000000;
         default: lineMask = 32'h00000000;
      endcase
   endfunction

   // Function B choice that reaches pins; memory controller has only A
   function automatic logic [31:0] activeB(input lines_t b, input int c);
      if (c == `LM_CTRL_MEM) begin
         activeB = 32'h00000000;
      end else begin
         activeB = b[c];
      end
   endfunction

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
   endfunction

   // Offsets that answer OKAY; everything else gets SLVERR
   function automatic logic mapped(input logic [7:0] a, input logic rd);
      mapped = 1'b0;
      if (a == `LM_GLOBAL_ADDR) begin
         mapped = rd;
      end else if (a[7] == 1'b0 && a[1:0] == 2'b00) begin
         if (rd) begin
            mapped = a[4:2] <= `LM_REG_PIN;
         end else begin
            mapped = a[4:2] != `LM_REG_STAT && a[4:2] <= `LM_REG_PULL;
         end
      end
   endfunction

   // Write and read channels accept when the previous answer is gone
   assign wrFire = axiReq.awvalid & axiReq.wvalid & ~state_reg.bvalid;
   assign rdFire = axiReq.arvalid & ~state_reg.rvalid;
   assign axiRsp.awready = axiReq.wvalid & ~state_reg.bvalid;
   assign axiRsp.wready = axiReq.awvalid & ~state_reg.bvalid;
   assign axiRsp.arready = ~state_reg.rvalid;
   assign axiRsp.bvalid = state_reg.bvalid;
   assign axiRsp.bresp = state_reg.bresp;
   assign axiRsp.rvalid = state_reg.rvalid;
   assign axiRsp.rdata = state_reg.rdata;
   assign axiRsp.rresp = state_reg.rresp;
   assign pad = state_reg.pad;
   assign wideAccessOk = state_reg.wide;

   // Inputs handed to whichever function owns the line
   always_comb begin
      for (int c = 0; c < `LM_CTRLS; c++) begin
         fnAIn[c] = state_reg.sync2[c] & state_reg.psel[c]
                    & ~activeB(state_reg.bsel, c);
         fnBIn[c] = state_reg.sync2[c] & state_reg.psel[c]
                    & activeB(state_reg.bsel, c);
      end
   end

   // Next state: registers, bus answers, pad drive
   always_comb begin
      logic [1:0] ci;
      logic [31:0] m;
      logic [31:0] selB;
      logic [31:0] fout;
      logic [31:0] foe;
      ci = axiReq.awaddr[6:5];
      m = 32'h00000000;
      selB = 32'h00000000;
      fout = 32'h00000000;
      foe = 32'h00000000;
      state_next = state_reg;
      // Pins pass two flops before anything looks at them
      state_next.sync1 = pinIn;
      state_next.sync2 = state_reg.sync1;

      // Register writes
      if (wrFire) begin
         m = lineMask(ci);
         state_next.bvalid = 1'b1;
         state_next.bresp = mapped(axiReq.awaddr, 1'b0) ?
                            `LM_RESP_OKAY : `LM_RESP_SLVERR;
         if (mapped(axiReq.awaddr, 1'b0) && !axiReq.awaddr[7]) begin
            case (axiReq.awaddr[4:2])
               `LM_REG_PSEL: state_next.psel[ci] = m & merge(
                  state_reg.psel[ci], axiReq.wdata, axiReq.wstrb);
               `LM_REG_BSEL: state_next.bsel[ci] = m & merge(
                  state_reg.bsel[ci], axiReq.wdata, axiReq.wstrb);
               `LM_REG_ODATA: state_next.odata[ci] = m & merge(
                  state_reg.odata[ci], axiReq.wdata, axiReq.wstrb);
               `LM_REG_OEN: state_next.oen[ci] = m & merge(
                  state_reg.oen[ci], axiReq.wdata, axiReq.wstrb);
               `LM_REG_PULL: state_next.pull[ci] = m & merge(
                  state_reg.pull[ci], axiReq.wdata, axiReq.wstrb);
               default: state_next.bresp = `LM_RESP_SLVERR;
            endcase
         end
      end else if (axiReq.bready) begin
         state_next.bvalid = 1'b0;
      end

      // Register reads
      if (rdFire) begin
         ci = axiReq.araddr[6:5];
         state_next.rvalid = 1'b1;
         state_next.rdata = 32'h00000000;
         state_next.rresp = mapped(axiReq.araddr, 1'b1) ?
                            `LM_RESP_OKAY : `LM_RESP_SLVERR;
         if (axiReq.araddr == `LM_GLOBAL_ADDR) begin
            state_next.rdata = {30'h00000000, OUT_CTRL_PRESENT,
                                state_reg.wide};
         end else if (mapped(axiReq.araddr, 1'b1)) begin
            case (axiReq.araddr[4:2])
               `LM_REG_PSEL: state_next.rdata = state_reg.psel[ci];
               `LM_REG_STAT: state_next.rdata = state_reg.psel[ci];
               `LM_REG_BSEL: state_next.rdata = state_reg.bsel[ci];
               `LM_REG_ODATA: state_next.rdata = state_reg.odata[ci];
               `LM_REG_OEN: state_next.rdata = state_reg.oen[ci];
               `LM_REG_PULL: state_next.rdata = state_reg.pull[ci];
               `LM_REG_PIN: state_next.rdata =
                  state_reg.sync2[ci] & lineMask(ci);
               default: state_next.rdata = 32'h00000000;
            endcase
         end
      end else if (axiReq.rready) begin
         state_next.rvalid = 1'b0;
      end

      // Pad drive per controller; trades one cycle of latency for clean pads
      for (int c = 0; c < `LM_CTRLS; c++) begin
         m = lineMask(2'(c));
         selB = activeB(state_reg.bsel, c);
         fout = (fnA.out[c] & ~selB) | (fnB.out[c] & selB);
         foe = (fnA.oe[c] & ~selB) | (fnB.oe[c] & selB);
         if (c == `LM_CTRL_OUT) begin
            foe = 32'hFFFFFFFF;
         end
         state_next.pad.out[c] = m & ((state_reg.psel[c] & fout)
                                 | (~state_reg.psel[c] & state_reg.odata[c]));
         state_next.pad.oe[c] = m & ((state_reg.psel[c] & foe)
                                | (~state_reg.psel[c] & state_reg.oen[c]));
         state_next.pad.pull[c] = m & state_reg.pull[c];
      end
      // Upper data lines in I/O use rule out 32-bit bus cycles
      state_next.wide = &state_reg.psel[`LM_CTRL_MEM][31:16];
   end

   // Reset puts I/O lines to pulled inputs, memory lines 7-13 to peripheral
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
         state_reg.psel[`LM_CTRL_MEM] <= `LM_PSEL_RST_MEM;
         state_reg.pull <= {OUT_MASK, `LM_MASK_2,
                            `LM_MASK_1, `LM_MASK_0};
         // Pads show the pull-ups already while reset is held
         state_reg.pad.pull <= {OUT_MASK, `LM_MASK_2,
                                `LM_MASK_1, `LM_MASK_0};
      end else begin
         state_reg <= state_next;
      end
   end

   // Helper: low while reset is held and in the first cycle after its release
   logic seen;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         seen <= 1'b0;
      end else begin
         seen <= 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_absent_lines;
      pad.oe[1][31:30] == 2'b00 && pad.oe[3][31:28] == 4'h0;
   endproperty
   a_absent_lines: assert property (p_absent_lines)
      else $error("absent line driven");

   property p_fn_a_route;
      (state_reg.psel[0][0] && !state_reg.bsel[0][0]) |=>
         pad.out[0][0] == $past(fnA.out[0][0]);
   endproperty
   a_fn_a_route: assert property (p_fn_a_route)
      else $error("line not following function A");

   property p_reset_pull;
      !seen |-> state_reg.pull[0] == `LM_MASK_0 && pad.oe[0] == 32'h0
                && pad.pull[0] == `LM_MASK_0;
   endproperty
   a_reset_pull: assert property (p_reset_pull)
      else $error("io line not a pulled input at reset");

   property p_reset_status;
      !seen |-> state_reg.psel[0] == 32'h0 && state_reg.psel[1] == 32'h0;
   endproperty
   a_reset_status: assert property (p_reset_status)
      else $error("io line status not clear at reset");

   property p_reset_mem;
      !seen |-> state_reg.psel[2] == `LM_PSEL_RST_MEM
                && state_reg.pull[2] == `LM_MASK_2;
   endproperty
   a_reset_mem: assert property (p_reset_mem)
      else $error("memory lines not peripheral at reset");

   property p_mem_no_b;
      (state_reg.psel[2][20] && state_reg.bsel[2][20]) |=>
         pad.out[2][20] == $past(fnA.out[2][20]);
   endproperty
   a_mem_no_b: assert property (p_mem_no_b)
      else $error("memory controller took function B");

   property p_wide;
      !state_reg.psel[2][16] |=> !wideAccessOk;
   endproperty
   a_wide: assert property (p_wide)
      else $error("wide access allowed with upper data as io");

   property p_out_ctrl;
      state_reg.psel[3][8] |=> pad.oe[3][8] == OUT_CTRL_PRESENT;
   endproperty
   a_out_ctrl: assert property (p_out_ctrl)
      else $error("output controller line not driven");

   sequence s_stat_read;
      rdFire && axiReq.araddr == 8'h04;
   endsequence
   property p_stat_read;
      s_stat_read |=> axiRsp.rdata == $past(state_reg.psel[0]);
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("status read differs from assignment");
endmodule
`default_nettype wire

// ==== logic/line_mux_consts.svh ====
// Address map, line masks and reset values of the line multiplexer
`ifndef LINE_MUX_CONSTS_SVH
`define LINE_MUX_CONSTS_SVH
`define LM_ADDR_W 8
`define LM_LINES 32
`define LM_CTRLS 4
`define LM_CTRL_MEM 2
`define LM_CTRL_OUT 3
`define LM_GLOBAL_ADDR 8'h80
`define LM_REG_PSEL 3'h0
`define LM_REG_STAT 3'h1
`define LM_REG_BSEL 3'h2
`define LM_REG_ODATA 3'h3
`define LM_REG_OEN 3'h4
`define LM_REG_PULL 3'h5
`define LM_REG_PIN 3'h6
`define LM_MASK_0 32'hFFFFFFFF
`define LM_MASK_1 32'h3FFFFFFF
`define LM_MASK_2 32'hFFFFFFFF
`define LM_MASK_3 32'h0FFFFFFF
`define LM_PSEL_RST_MEM 32'h00003F80
`define LM_WIDE_LO 16
`define LM_WIDE_HI 31
`define LM_RESP_OKAY 2'h0
`define LM_RESP_SLVERR 2'h2
`endif

// ==== logic/line_mux_pkg.sv ====
// Types shared by the line multiplexer and its bench
package line_mux_pkg;
   typedef logic [3:0][31:0] lines_t;
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } axi_req_s;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_s;
   // Pad side of every line
   typedef struct packed {
      lines_t out;
      lines_t oe;
      lines_t pull;
   } pad_s;
   // Drive offered by one peripheral function
   typedef struct packed {
      lines_t out;
      lines_t oe;
   } fn_s;
endpackage

// ==== verif/io_line_peripheral_mux_bench.sv ====
// Self-checking bench for the line multiplexer
`timescale 1ns/1ns
`default_nettype none
`include "line_mux_consts.svh"
module io_line_peripheral_mux_bench;
   import line_mux_pkg::*;
   localparam lines_t A_OUT = {4{32'hA5C3F00F}};
   localparam lines_t A_OE = {4{32'h0F0FFFFF}};
   localparam lines_t B_OUT = {4{32'h5A3C0FF0}};
   localparam lines_t B_OE = {4{32'hFFFF0F0F}};
   localparam lines_t MASKS = {`LM_MASK_3, `LM_MASK_2, `LM_MASK_1,
      `LM_MASK_0};
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   axi_req_s axiReq = '0;
   axi_rsp_s axiRsp;
   fn_s fnA;
   fn_s fnB;
   lines_t fnAIn;
   lines_t fnBIn;
   lines_t pinIn;
   lines_t extIn = '0;
   pad_s pad;
   logic wideAccessOk;
   int miscompares = 0;
   int num_checks = 0;
   logic [31:0] rdv;
   logic [1:0] resp;

   io_line_peripheral_mux #(.OUT_CTRL_PRESENT(1'b1)) DUT (
      .ref_clk(ref_clk), .resetn(resetn), .axiReq(axiReq),
      .axiRsp(axiRsp), .fnA(fnA), .fnB(fnB), .fnAIn(fnAIn),
      .fnBIn(fnBIn), .pinIn(pinIn), .pad(pad),
      .wideAccessOk(wideAccessOk));

   line_fn_model #(.A_OUT(A_OUT), .A_OE(A_OE), .B_OUT(B_OUT),
      .B_OE(B_OE)) partner (.pad(pad), .extIn(extIn), .fnA(fnA),
      .fnB(fnB), .pinIn(pinIn));

   // Free-running 100 MHz clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   function automatic logic [7:0] ad(input int c, input logic [2:0] r);
      return 8'(c * 32 + r * 4);
   endfunction

   // Write master: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      axiReq.awaddr <= a;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hF;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      // Each channel released at its own ready
      while (!(awDone && wDone)) begin
         @(posedge ref_clk);
         if (!awDone && axiRsp.awready === 1'b1) begin
            awDone = 1'b1;
            axiReq.awvalid <= 1'b0;
         end
         if (!wDone && axiRsp.wready === 1'b1) begin
            wDone = 1'b1;
            axiReq.wvalid <= 1'b0;
         end
      end
      axiReq.bready <= 1'b1;
      do @(posedge ref_clk); while (axiRsp.bvalid !== 1'b1);
      resp = axiRsp.bresp;
      axiReq.bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      do @(posedge ref_clk); while (axiRsp.arready !== 1'b1);
      axiReq.arvalid <= 1'b0;
      axiReq.rready <= 1'b1;
      do @(posedge ref_clk); while (axiRsp.rvalid !== 1'b1);
      rdv = axiRsp.rdata;
      resp = axiRsp.rresp;
      axiReq.rready <= 1'b0;
   endtask

   // Pads and gated inputs of one controller against its selection
   task automatic chk_pad(input int c, input logic [31:0] ps,
      input logic [31:0] bs);
      logic [31:0] eb;
      logic [31:0] eo;
      logic [31:0] ee;
      ps = ps & MASKS[c];
      eb = (c == `LM_CTRL_MEM) ? 32'h00000000 : bs & ps;
      eo = ((A_OUT[c] & ~eb) | (B_OUT[c] & eb)) & ps;
      ee = (c == `LM_CTRL_OUT) ? ps : ((A_OE[c] & ~eb) | (B_OE[c] & eb)) & ps;
      repeat (3) @(posedge ref_clk);
      #1;
      check(pad.out[c], eo);
      check(pad.oe[c], ee);
      check(fnAIn[c], ((ee & eo) | (~ee & MASKS[c])) & ps & ~eb);
      check(fnBIn[c], ((ee & eo) | (~ee & MASKS[c])) & eb);
      @(posedge ref_clk);
   endtask

   // Reset state of every controller
   task automatic t_reset();
      for (int c = 0; c < 4; c++) begin
         rd(ad(c, `LM_REG_STAT));
         check(rdv, c == 2 ? `LM_PSEL_RST_MEM : '0);
         rd(ad(c, `LM_REG_PULL));
         check(rdv, MASKS[c]);
         check(pad.pull[c], MASKS[c]);
         chk_pad(c, c == 2 ? `LM_PSEL_RST_MEM : 32'h00000000, 32'h0);
      end
      check(32'(wideAccessOk), 32'h00000000);
      rd(`LM_GLOBAL_ADDR);
      check(rdv, 32'h00000002);
      check(32'(resp), 32'(`LM_RESP_OKAY));
   endtask

   // Hand every line to A or B, then give it back to I/O
   task automatic t_select();
      for (int c = 0; c < 4; c++) begin
         wr(ad(c, `LM_REG_PSEL), 32'hFFFFFFFF);
         wr(ad(c, `LM_REG_BSEL), 32'hF0F0F0F0);
         rd(ad(c, `LM_REG_STAT));
         check(rdv, MASKS[c]);
         chk_pad(c, 32'hFFFFFFFF, 32'hF0F0F0F0);
         wr(ad(c, `LM_REG_PSEL), 32'h00000000);
         rd(ad(c, `LM_REG_STAT));
         check(rdv, 32'h00000000);
         chk_pad(c, 32'h00000000, 32'hF0F0F0F0);
      end
   endtask

   // Upper data lines as I/O forbid wide accesses
   task automatic t_wide();
      wr(ad(2, `LM_REG_PSEL), 32'hFFFF0000);
      repeat (3) @(posedge ref_clk);
      check(32'(wideAccessOk), 32'h00000001);
      wr(ad(2, `LM_REG_PSEL), 32'hFFEF0000);
      repeat (3) @(posedge ref_clk);
      check(32'(wideAccessOk), 32'h00000000);
   endtask

   // Own drive, pull and pin readback on lines kept as I/O
   task automatic t_io();
      extIn[0] <= 32'h000000A5;
      wr(ad(0, `LM_REG_ODATA), 32'h12345678);
      wr(ad(0, `LM_REG_OEN), 32'hFFFF0000);
      wr(ad(0, `LM_REG_PULL), 32'h0000FF00);
      check(32'(resp), 32'(`LM_RESP_OKAY));
      repeat (3) @(posedge ref_clk);
      check(pad.out[0], 32'h12345678);
      check(pad.oe[0], 32'hFFFF0000);
      check(pad.pull[0], 32'h0000FF00);
      rd(ad(0, `LM_REG_PIN));
      check(rdv, 32'h1234FFA5);
      check(fnAIn[0], 32'h00000000);
   endtask

   // Read-only status and unmapped address are refused
   task automatic t_err();
      wr(ad(0, `LM_REG_STAT), 32'hFFFFFFFF);
      check(32'(resp), 32'(`LM_RESP_SLVERR));
      rd(ad(0, `LM_REG_STAT));
      check(rdv, 32'h00000000);
      rd(8'h84);
      check(32'(resp), 32'(`LM_RESP_SLVERR));
      check(rdv, 32'h00000000);
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      // Pulled inputs already while reset is held
      check(pad.pull[0], MASKS[0]);
      check(pad.oe[0], 32'h00000000);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_select();
      t_wide();
      t_io();
      t_err();
      summarize();
   end

   // Hang guard, far beyond the hundred and fifty or so cycles the tests need
   initial begin
      #200000;
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire

// ==== verif/line_fn_model.sv ====
// Behavioural peripheral functions and pad wiring around the line mux
`timescale 1ns/1ns
`default_nettype none
module line_fn_model #(
   parameter line_mux_pkg::lines_t A_OUT = '0,
   parameter line_mux_pkg::lines_t A_OE = '0,
   parameter line_mux_pkg::lines_t B_OUT = '0,
   parameter line_mux_pkg::lines_t B_OE = '0
) (
   input wire line_mux_pkg::pad_s pad,
   input wire line_mux_pkg::lines_t extIn,
   output line_mux_pkg::fn_s fnA,
   output line_mux_pkg::fn_s fnB,
   output line_mux_pkg::lines_t pinIn
);
   import line_mux_pkg::*;

   // Fixed drive patterns, distinct per function so a wrong pick shows
   assign fnA.out = A_OUT;
   assign fnA.oe = A_OE;
   assign fnB.out = B_OUT;
   assign fnB.oe = B_OE;

   // Pin level: own drive first, then pull-up, else the outside world
   assign pinIn = (pad.oe & pad.out) | (~pad.oe & pad.pull) |
      (~pad.oe & ~pad.pull & extIn);
endmodule
`default_nettype wire
